// >>> hdl/dbguart_pkg.sv
// package: register map, field positions and constants of the debug two-pin uart
package dbguart_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] DBGU_CMD_OFF    = 12'h000;
  localparam logic [11:0] DBGU_CFG_OFF    = 12'h004;
  localparam logic [11:0] DBGU_STAT_OFF   = 12'h014;
  localparam logic [11:0] DBGU_RXHOLD_OFF = 12'h018;
  localparam logic [11:0] DBGU_TXHOLD_OFF = 12'h01C;
  localparam logic [11:0] DBGU_BAUD_OFF   = 12'h020;
  localparam logic [11:0] DBGU_ID1_OFF    = 12'h040;
  localparam logic [11:0] DBGU_ID2_OFF    = 12'h044;
  localparam logic [11:0] DBGU_CHAN_OFF   = 12'h100;

  // ----------------------------------------------------------------
  // command bit positions
  // ----------------------------------------------------------------
  localparam int CMD_RXRST  = 2;
  localparam int CMD_TXRST  = 3;
  localparam int CMD_RXON   = 4;
  localparam int CMD_RXOFF  = 5;
  localparam int CMD_TXON   = 6;
  localparam int CMD_TXOFF  = 7;
  localparam int CMD_CLRERR = 8;

  // ----------------------------------------------------------------
  // config fields and status bits
  // ----------------------------------------------------------------
  localparam int CFG_CHK_LSB  = 9;
  localparam int CFG_MODE_LSB = 14;
  localparam int ST_RXF    = 0;
  localparam int ST_TXF    = 1;
  localparam int ST_OVR    = 5;
  localparam int ST_FRAME  = 6;
  localparam int ST_CHK    = 7;
  localparam int ST_TXDONE = 9;
  localparam int ST_D2C    = 31;
  localparam int ST_C2D    = 30;
  localparam int ID_XID_BIT = 31;

  // ----------------------------------------------------------------
  // timing counts, in sample (16x) ticks, and register reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] START_MIN   = 5'h07;
  localparam logic [4:0] FIRST_SAMP  = 5'h18;
  localparam logic [4:0] BIT_SAMP    = 5'h10;
  localparam logic [3:0] OVERSAMPLE  = 4'hF;
  localparam logic [15:0] BAUD_RST   = 16'h0000;
  localparam logic [2:0]  CFG_CHK_RST = 3'h0;

  typedef enum logic [1:0]
  {
    MODE_NORMAL = 2'b00,
    MODE_ECHO   = 2'b01,
    MODE_LOCAL  = 2'b10,
    MODE_REMOTE = 2'b11
  } dbgu_mode_t;

  typedef enum logic [1:0]
  {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10
  } dbgu_rx_st_t;

  typedef enum logic [1:0]
  {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01
  } dbgu_tx_st_t;

endpackage

// >>> hdl/dbgu_uart.sv
// debug two-pin uart with axi4-lite register slave
// Functional notes
// - bit clock is master clock over sixteen times divisor; zero divisor stops port
// - receiver disabled at reset; enable command starts start-bit search
// - receive disable stops at once if idle, else after stop bit
// - receiver reset aborts reception immediately and disables receiver
// - start bit accepted only if low longer than seven sample ticks
// - first data sample 24 ticks after falling edge, then every 16
// - completed char goes to holding reg, sets ready; read clears ready
// - new char while ready set raises overrun until error clear command
// - parity mismatch sets parity error with ready; cleared only by command
// - low stop bit sets framing error with ready; cleared by command
// - transmitter disabled at reset; after enable waits for a written char
// - transmit disable finishes shifting and held char before stopping
// - transmitter reset stops transmission immediately
// - frame: low start, 8 data lsb first, optional parity, high stop
// - holding free set on enable, drops on write, rises on transfer
// - all-done rises after last stop bit with both registers empty
// - ready flags drive channel request outputs; channel area from 0x100
// - echo mode drives input pin straight to output pin
// - local loopback feeds transmitter to receiver, output held high
// - remote loopback ties input to output, uart disabled
// - two debug-channel flags read as top two status bits
// - two read-only id registers; second reads zero without extension bit
// - parity field: even, odd, forced 0, forced 1, none when top bit set
module dbgu_uart
  import dbguart_pkg::*;
#(
  parameter logic [31:0] ID_PRIMARY   = 32'h8000_0001, // arbitrary value
  parameter logic [31:0] ID_SECONDARY = 32'h0000_0002  // arbitrary value
)
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // serial pins
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  // debug channel flags
  input  wire logic        debugger_to_cpu_pending,
  input  wire logic        cpu_to_debugger_pending,
  // transfer channel requests
  output logic             rx_chan_req,
  output logic             tx_chan_req
);

  // ------
  // bus slave
  // ------
  logic        aw_have_q, w_have_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire, rd_fire;
  logic        cmd_wr, thr_wr, rhr_rd;
  logic [31:0] rd_val;

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign cmd_wr  = wr_fire && aw_addr_q == DBGU_CMD_OFF && w_strb_q[0] && w_strb_q[1];
  assign thr_wr  = wr_fire && aw_addr_q == DBGU_TXHOLD_OFF && w_strb_q[0];
  assign rhr_rd  = rd_fire && {s_axi_araddr[11:2], 2'b00} == DBGU_RXHOLD_OFF;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 12'h000;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        // writes to unmapped or read-only words are ignored but answered okay
        s_axi_bresp  <= 2'b00;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
      end
    end
  end

  // ------
  // configuration registers
  // ------
  logic [15:0] baud_divisor_q;
  logic [2:0]  check_bit_type_q;
  dbgu_mode_t  loopback_select_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      baud_divisor_q    <= BAUD_RST;
      check_bit_type_q  <= CFG_CHK_RST;
      loopback_select_q <= MODE_NORMAL;
    end
    else if (wr_fire && aw_addr_q == DBGU_BAUD_OFF)
    begin
      if (w_strb_q[0])
        baud_divisor_q[7:0] <= w_data_q[7:0];
      if (w_strb_q[1])
        baud_divisor_q[15:8] <= w_data_q[15:8];
    end
    else if (wr_fire && aw_addr_q == DBGU_CFG_OFF && w_strb_q[1])
    begin
      check_bit_type_q  <= w_data_q[CFG_CHK_LSB +: 3];
      loopback_select_q <= dbgu_mode_t'(w_data_q[CFG_MODE_LSB +: 2]);
    end
  end

  // ------
  // sample tick at sixteen times the baud rate
  // ------
  logic [15:0] div_cnt_q;
  logic        tick_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || baud_divisor_q == 16'h0000)
    begin
      div_cnt_q <= 16'h0001;
      tick_q    <= 1'b0;
    end
    else if (div_cnt_q >= baud_divisor_q)
    begin
      div_cnt_q <= 16'h0001;
      tick_q    <= 1'b1;
    end
    else
    begin
      div_cnt_q <= div_cnt_q + 16'h0001;
      tick_q    <= 1'b0;
    end
  end

  // ------
  // pin synchroniser
  // ------
  logic [2:0] rx_sync_q;
  logic       rx_pin_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_sync_q <= 3'h7;
      rx_pin_q  <= 1'b1;
    end
    else
    begin
      rx_sync_q <= {rx_sync_q[1:0], serial_in_pin};
      if (rx_sync_q[2] == rx_sync_q[1])
        rx_pin_q <= rx_sync_q[2];
    end
  end

  // ------
  // receiver
  // ------
  logic        tx_line_q;
  logic        rx_line;
  dbgu_rx_st_t rx_st_q;
  logic        rx_en_q, rx_stop_pend_q;
  logic [4:0]  rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic [8:0]  rx_shift_q;
  logic [7:0]  rx_hold_q;
  logic        rx_ready_q, ovr_q, chk_err_q, frame_err_q;
  logic        rx_done, rx_chk_bad;
  logic [3:0]  rx_nbits;
  logic        chk_on;

  assign chk_on     = !check_bit_type_q[2];
  assign rx_nbits   = chk_on ? 4'h9 : 4'h8;
  // local loopback: transmitter feeds receiver, pin ignored
  assign rx_line    = (loopback_select_q == MODE_LOCAL) ? tx_line_q : rx_pin_q;
  assign rx_done    = rx_st_q == RX_BITS && tick_q && rx_cnt_q == 5'h00
                      && rx_bit_q == rx_nbits;
  assign rx_chk_bad = chk_on && (rx_shift_q[8] != chk_of(rx_shift_q[7:0]));

  // parity of the data bits for the selected type
  function automatic logic chk_of(input logic [7:0] d);
    case (check_bit_type_q[1:0])
      2'b00:   chk_of = ^d;
      2'b01:   chk_of = ~(^d);
      2'b10:   chk_of = 1'b0;
      default: chk_of = 1'b1;
    endcase
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_en_q        <= 1'b0;
      rx_stop_pend_q <= 1'b0;
    end
    else if (cmd_wr && w_data_q[CMD_RXRST])
    begin
      rx_en_q        <= 1'b0;
      rx_stop_pend_q <= 1'b0;
    end
    else if (cmd_wr && w_data_q[CMD_RXOFF])
    begin
      if (rx_st_q == RX_IDLE)
        rx_en_q <= 1'b0;
      else
        rx_stop_pend_q <= 1'b1;
    end
    else if (cmd_wr && w_data_q[CMD_RXON])
    begin
      rx_en_q        <= 1'b1;
      rx_stop_pend_q <= 1'b0;
    end
    else if (rx_stop_pend_q && (rx_done || rx_st_q == RX_IDLE))
    begin
      rx_en_q        <= 1'b0;
      rx_stop_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_en_q || loopback_select_q == MODE_REMOTE
        || (cmd_wr && w_data_q[CMD_RXRST]))
    begin
      rx_st_q    <= RX_IDLE;
      rx_cnt_q   <= 5'h00;
      rx_bit_q   <= 4'h0;
      rx_shift_q <= 9'h000;
    end
    else if (tick_q)
    begin
      case (rx_st_q)
        RX_IDLE:
          if (!rx_line)
          begin
            rx_st_q  <= RX_START;
            rx_cnt_q <= 5'h01;
          end
        RX_START:
          if (rx_line)
            rx_st_q <= RX_IDLE;
          else if (rx_cnt_q == START_MIN)
          begin
            // low for more than seven ticks; next sample lands at tick 24
            rx_st_q  <= RX_BITS;
            rx_cnt_q <= FIRST_SAMP - START_MIN - 5'h01;
            rx_bit_q <= 4'h0;
          end
          else
            rx_cnt_q <= rx_cnt_q + 5'h01;
        RX_BITS:
          if (rx_cnt_q != 5'h00)
            rx_cnt_q <= rx_cnt_q - 5'h01;
          else if (rx_bit_q == rx_nbits)
            rx_st_q <= RX_IDLE;
          else
          begin
            rx_shift_q[rx_bit_q] <= rx_line;
            rx_bit_q <= rx_bit_q + 4'h1;
            rx_cnt_q <= BIT_SAMP - 5'h01;
          end
        default:
          rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // flags: a completing character wins over a same-cycle clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_hold_q   <= 8'h00;
      rx_ready_q  <= 1'b0;
      ovr_q       <= 1'b0;
      chk_err_q   <= 1'b0;
      frame_err_q <= 1'b0;
    end
    else if (rx_done)
    begin
      rx_hold_q  <= rx_shift_q[7:0];
      rx_ready_q <= 1'b1;
      if (rx_ready_q && !rhr_rd)
        ovr_q <= 1'b1;
      else if (cmd_wr && w_data_q[CMD_CLRERR])
        ovr_q <= 1'b0;
      if (rx_chk_bad)
        chk_err_q <= 1'b1;
      else if (cmd_wr && w_data_q[CMD_CLRERR])
        chk_err_q <= 1'b0;
      if (!rx_line)
        frame_err_q <= 1'b1;
      else if (cmd_wr && w_data_q[CMD_CLRERR])
        frame_err_q <= 1'b0;
    end
    else
    begin
      if (rhr_rd)
        rx_ready_q <= 1'b0;
      if (cmd_wr && w_data_q[CMD_CLRERR])
      begin
        ovr_q       <= 1'b0;
        chk_err_q   <= 1'b0;
        frame_err_q <= 1'b0;
      end
    end
  end

  // ------
  // transmitter
  // ------
  dbgu_tx_st_t tx_st_q;
  logic        tx_en_q, tx_stop_pend_q, tx_held_q, tx_free_q, tx_done_q;
  logic [7:0]  tx_hold_q;
  logic [10:0] tx_shift_q;
  logic [3:0]  tx_bits_q, tx_tick_q;
  logic        tx_rst, tx_load;

  assign tx_rst  = cmd_wr && w_data_q[CMD_TXRST];
  assign tx_load = tx_st_q == TX_IDLE && tx_held_q && tick_q && tx_en_q
                   && loopback_select_q != MODE_REMOTE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || tx_rst)
    begin
      tx_en_q        <= 1'b0;
      tx_stop_pend_q <= 1'b0;
      tx_held_q      <= 1'b0;
      tx_free_q      <= 1'b0;
      tx_hold_q      <= 8'h00;
    end
    else
    begin
      if (cmd_wr && w_data_q[CMD_TXOFF])
        tx_stop_pend_q <= 1'b1;
      else if (cmd_wr && w_data_q[CMD_TXON])
      begin
        tx_en_q   <= 1'b1;
        tx_free_q <= !tx_held_q;
      end
      else if (tx_stop_pend_q && tx_st_q == TX_IDLE && !tx_held_q)
      begin
        // only stops once both the shifter and the holding slot are empty
        tx_en_q        <= 1'b0;
        tx_stop_pend_q <= 1'b0;
        tx_free_q      <= 1'b0;
      end
      if (thr_wr && tx_en_q && tx_free_q)
      begin
        tx_hold_q <= w_data_q[7:0];
        tx_held_q <= 1'b1;
        tx_free_q <= 1'b0;
      end
      else if (tx_load)
      begin
        tx_held_q <= 1'b0;
        tx_free_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || tx_rst)
    begin
      tx_st_q    <= TX_IDLE;
      tx_shift_q <= 11'h7FF;
      tx_bits_q  <= 4'h0;
      tx_tick_q  <= 4'h0;
      tx_line_q  <= 1'b1;
      tx_done_q  <= 1'b0;
    end
    else if (tick_q)
    begin
      case (tx_st_q)
        TX_IDLE:
        begin
          tx_line_q <= 1'b1;
          tx_done_q <= tx_en_q && !tx_held_q;
          if (tx_load)
          begin
            tx_st_q    <= TX_SHIFT;
            tx_done_q  <= 1'b0;
            tx_shift_q <= chk_on ? {1'b1, chk_of(tx_hold_q), tx_hold_q, 1'b0}
                                 : {2'b11, tx_hold_q, 1'b0};
            tx_bits_q  <= chk_on ? 4'hB : 4'hA;
            tx_tick_q  <= 4'h0;
          end
        end
        TX_SHIFT:
        begin
          tx_line_q <= tx_shift_q[0];
          tx_tick_q <= tx_tick_q + 4'h1;
          if (tx_tick_q == OVERSAMPLE)
          begin
            tx_shift_q <= {1'b1, tx_shift_q[10:1]};
            tx_bits_q  <= tx_bits_q - 4'h1;
            if (tx_bits_q == 4'h1)
              tx_st_q <= TX_IDLE;
          end
        end
        default:
          tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // ------
  // pin mux and channel requests
  // ------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      serial_out_pin <= 1'b1;
      rx_chan_req    <= 1'b0;
      tx_chan_req    <= 1'b0;
    end
    else
    begin
      case (loopback_select_q)
        MODE_ECHO:   serial_out_pin <= rx_pin_q;
        MODE_LOCAL:  serial_out_pin <= 1'b1;
        MODE_REMOTE: serial_out_pin <= rx_pin_q;
        default:     serial_out_pin <= tx_line_q;
      endcase
      rx_chan_req <= rx_ready_q && !rhr_rd;
      tx_chan_req <= tx_free_q && !thr_wr;
    end
  end

  // ------
  // read data
  // ------
  always_comb
  begin
    rd_val = 32'h0000_0000;
    case ({s_axi_araddr[11:2], 2'b00})
      DBGU_CFG_OFF:
      begin
        rd_val[CFG_CHK_LSB +: 3]  = check_bit_type_q;
        rd_val[CFG_MODE_LSB +: 2] = loopback_select_q;
      end
      DBGU_STAT_OFF:
      begin
        rd_val[ST_RXF]    = rx_ready_q;
        rd_val[ST_TXF]    = tx_free_q;
        rd_val[ST_OVR]    = ovr_q;
        rd_val[ST_FRAME]  = frame_err_q;
        rd_val[ST_CHK]    = chk_err_q;
        rd_val[ST_TXDONE] = tx_done_q;
        rd_val[ST_D2C]    = debugger_to_cpu_pending;
        rd_val[ST_C2D]    = cpu_to_debugger_pending;
      end
      DBGU_RXHOLD_OFF: rd_val[7:0] = rx_hold_q;
      DBGU_BAUD_OFF:   rd_val[15:0] = baud_divisor_q;
      DBGU_ID1_OFF:    rd_val = ID_PRIMARY;
      DBGU_ID2_OFF:    rd_val = ID_PRIMARY[ID_XID_BIT] ? ID_SECONDARY : 32'h0000_0000;
      default:         rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= 2'b00;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> dv/dbgu_uart_asserts.sv
// checker: port-level properties of the debug uart
module dbgu_uart_asserts
  import dbguart_pkg::*;
#(
  parameter logic [31:0] ID_PRIMARY   = 32'h0,
  parameter logic [31:0] ID_SECONDARY = 32'h0
)
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // axi4-lite
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // status sources and requests
  input wire logic        debugger_to_cpu_pending,
  input wire logic        cpu_to_debugger_pending,
  input wire logic        rx_chan_req,
  input wire logic        tx_chan_req
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire logic ar_hs = s_axi_arvalid && s_axi_arready;

  AST_BRESP: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("write response not okay");
  AST_RRESP: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
    else $error("read response not okay");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_BVAL: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  AST_ID1: assert property (ar_hs && s_axi_araddr == DBGU_ID1_OFF
      |=> s_axi_rvalid && s_axi_rdata == ID_PRIMARY)
    else $error("primary id wrong");
  AST_ID2: assert property (ar_hs && s_axi_araddr == DBGU_ID2_OFF
      |=> s_axi_rdata == (ID_PRIMARY[ID_XID_BIT] ? ID_SECONDARY : 32'h0))
    else $error("secondary id wrong");
  AST_DBGF: assert property (ar_hs && s_axi_araddr == DBGU_STAT_OFF
      |=> {s_axi_rdata[ST_D2C], s_axi_rdata[ST_C2D]}
        == {$past(debugger_to_cpu_pending), $past(cpu_to_debugger_pending)})
    else $error("debug flags not in status");
  // only checked while the request is steady, since it may lag the status by a cycle
  AST_TXREQ: assert property (ar_hs && s_axi_araddr == DBGU_STAT_OFF && $stable(tx_chan_req)
      ##1 $stable(tx_chan_req) |-> s_axi_rvalid && s_axi_rdata[ST_TXF] == tx_chan_req)
    else $error("transmit request differs from status");
  AST_RXCLR: assert property (ar_hs && s_axi_araddr == DBGU_RXHOLD_OFF |=> !rx_chan_req)
    else $error("receive request not cleared by read");
endmodule

bind dbgu_uart dbgu_uart_asserts #(
  .ID_PRIMARY(ID_PRIMARY),
  .ID_SECONDARY(ID_SECONDARY)
) u_chk (
  .aclk, .aresetn, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rresp, .debugger_to_cpu_pending, .cpu_to_debugger_pending, .rx_chan_req, .tx_chan_req
);

// >>> dv/dbgu_term_model.sv
// partner: serial terminal that sends frames and decodes what comes back
module dbgu_term_model
#(
  parameter int BITC = 16
)
(
  // clock
  input wire logic aclk,
  // serial wires
  input wire logic rx_line,
  output logic     tx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  int         chk_mode = 4;
  logic [8:0] got_q[$];
  initial tx_line = 1'b1;

  function automatic logic pbit(input logic [7:0] b, input int p);
    case (p)
      0: return ^b;
      1: return ~^b;
      3: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // bad flips the check bit, stop low makes a framing fault
  task automatic send(input logic [7:0] b, input int p, input logic bad, input logic stop);
    logic [10:0] f;
    f = {stop, pbit(b, p) ^ bad, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      if (i != 9 || p < 4)
      begin
        tx_line <= f[i];
        repeat (BITC) @(posedge aclk);
      end
    end
    tx_line <= 1'b1;
    repeat (BITC) @(posedge aclk);
  endtask

  task automatic pulse(input int n);
    tx_line <= 1'b0;
    repeat (n) @(posedge aclk);
    tx_line <= 1'b1;
  endtask

  // mid-bit sampling keeps the decoder tolerant of small sync delays
  initial forever
  begin
    logic [8:0] v;
    @(negedge rx_line);
    repeat (BITC / 2) @(posedge aclk);
    v = 9'h0;
    for (int i = 0; i < (chk_mode < 4 ? 9 : 8); i++)
    begin
      repeat (BITC) @(posedge aclk);
      v[i] = rx_line;
    end
    repeat (BITC) @(posedge aclk);
    got_q.push_back(v);
  end
endmodule

// >>> dv/tb.sv
// testbench: register and serial tests of the debug uart
module tb
  import dbguart_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID_P = 32'h0000_0005; // arbitrary value
  localparam logic [31:0] ID_S = 32'h0000_00A7; // arbitrary value
  localparam logic [31:0] EN   = (32'h1 << CMD_RXON) | (32'h1 << CMD_TXON);
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        serial_in_pin, serial_out_pin, rx_chan_req, tx_chan_req;
  logic        debugger_to_cpu_pending = 1'b0, cpu_to_debugger_pending = 1'b0;
  logic [7:0]  b;
  int          errors = 0, n_compared = 0;

  dbgu_uart #(.ID_PRIMARY(ID_P), .ID_SECONDARY(ID_S)) dut (.*);
  dbgu_term_model term (.aclk(aclk), .rx_line(serial_out_pin), .tx_line(serial_in_pin));

  initial forever #4 aclk = ~aclk;

  // ------
  // bus and check tasks
  // ------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic wait_rx();
    rv = 32'h0;
    for (int i = 0; i < 100 && rv[ST_RXF] !== 1'b1; i++)
      rd(DBGU_STAT_OFF, rv);
  endtask

  task automatic get_tx(input logic [8:0] e);
    for (int i = 0; i < 400 && term.got_q.size() == 0; i++)
      @(posedge aclk);
    chk(32'h1, term.got_q.size());
    if (term.got_q.size() > 0)
      chk(e, term.got_q.pop_front());
    repeat (16) @(posedge aclk);
  endtask

  // disable or reset command lands in the middle of an incoming frame
  task automatic mid(input logic [31:0] c, input logic e);
    wr(DBGU_CMD_OFF, EN);
    fork
      term.send(8'hA5, 4, 1'b0, 1'b1);
      begin
        repeat (60) @(posedge aclk);
        wr(DBGU_CMD_OFF, c);
      end
    join
    repeat (40) @(posedge aclk);
    rd(DBGU_STAT_OFF, rv);
    chk(e, rv[ST_RXF]);
    rd(DBGU_RXHOLD_OFF, rv);
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ------
  // test sequence
  // ------
  initial
  begin
    void'($urandom(10));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(DBGU_ID1_OFF, rv);
    chk(ID_P, rv);
    rd(DBGU_ID2_OFF, rv);
    chk(ID_P[ID_XID_BIT] ? ID_S : 32'h0, rv);
    rd(DBGU_BAUD_OFF, rv);
    chk(32'h0, rv);
    rd(12'h030, rv);
    chk(32'h0, rv);
    wr(DBGU_BAUD_OFF, 32'h1);
    term.send(8'h55, 4, 1'b0, 1'b1);
    rd(DBGU_STAT_OFF, rv);
    chk(32'h0, rv[ST_RXF]);
    $display("test reset done");
    wr(DBGU_CMD_OFF, EN);
    for (int p = 0; p < 5; p++)
    begin
      wr(DBGU_CFG_OFF, 32'(p << CFG_CHK_LSB));
      term.chk_mode = p;
      b = 8'($urandom);
      term.send(b, p, 1'b0, 1'b1);
      wait_rx();
      rd(DBGU_RXHOLD_OFF, rv);
      chk(b, rv);
      rd(DBGU_STAT_OFF, rv);
      chk(32'h0, rv & 32'hE1);
      b = 8'($urandom);
      wr(DBGU_TXHOLD_OFF, b);
      get_tx({term.pbit(b, p), b});
      rd(DBGU_STAT_OFF, rv);
      chk(32'h202, rv & 32'h202);
    end
    wr(DBGU_TXHOLD_OFF, b);
    wr(DBGU_TXHOLD_OFF, {~b});
    rd(DBGU_STAT_OFF, rv);
    chk(32'h0, rv[ST_TXF]);
    get_tx({1'b0, b});
    get_tx({1'b0, ~b});
    $display("test format done");
    wr(DBGU_CFG_OFF, 32'h0);
    term.chk_mode = 0;
    term.send(b, 0, 1'b1, 1'b1);
    wait_rx();
    term.send({~b}, 0, 1'b0, 1'b0);
    repeat (40) @(posedge aclk);
    rd(DBGU_STAT_OFF, rv);
    chk(32'hE1, rv & 32'hE1);
    rd(DBGU_RXHOLD_OFF, rv);
    chk({~b}, rv);
    wr(DBGU_CMD_OFF, 32'h1 << CMD_CLRERR);
    rd(DBGU_STAT_OFF, rv);
    chk(32'h0, rv & 32'hE1);
    term.pulse(6);
    repeat (300) @(posedge aclk);
    rd(DBGU_STAT_OFF, rv);
    chk(32'h0, rv[ST_RXF]);
    $display("test errors done");
    term.chk_mode = 4;
    for (int m = 1; m < 4; m++)
    begin
      wr(DBGU_CFG_OFF, 32'((m << CFG_MODE_LSB) | (4 << CFG_CHK_LSB)));
      b = 8'($urandom);
      if (m == 2)
      begin
        wr(DBGU_TXHOLD_OFF, b);
        wait_rx();
        chk(32'h0, term.got_q.size());
      end
      else
      begin
        term.send(b, 4, 1'b0, 1'b1);
        get_tx({1'b0, b});
        rd(DBGU_STAT_OFF, rv);
        chk(m == 1, rv[ST_RXF]);
      end
      rd(DBGU_RXHOLD_OFF, rv);
      if (m != 3)
        chk(b, rv);
    end
    wr(DBGU_CFG_OFF, 32'(4 << CFG_CHK_LSB));
    for (int i = 0; i < 4; i++)
    begin
      {debugger_to_cpu_pending, cpu_to_debugger_pending} <= 2'(i);
      @(posedge aclk);
      rd(DBGU_STAT_OFF, rv);
      chk(i, rv[31:30]);
    end
    mid(32'h1 << CMD_RXOFF, 1'b1);
    mid(32'h1 << CMD_RXRST, 1'b0);
    $display("test modes done");
    complete_run();
  end

  initial
  begin
    repeat (40000) @(posedge aclk);
    errors++;
    complete_run();
  end
endmodule
